// >>> bench/lps_chk.sv
// checker for the controller to sdram command link: spacing, masks, exits
// assumes it is instantiated beside the link and sees its signals directly
`default_nettype none
module lps_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [lps_pkg::BW-1:0] ba,
  input wire logic [lps_pkg::MW-1:0] dqm,
  input wire logic dq_ctl_oe,
  input wire logic [lps_pkg::MW-1:0] dq_mem_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACT_PRE = lps_pkg::ACT_TO_PRE_MIN_CYC;
  localparam int DPD_NOP = lps_pkg::DPD_EXIT_NOP_CYC;
  localparam int ROW_CYC = lps_pkg::ROW_CYCLE_TIME_CYC;
  localparam int ACT_ACT = lps_pkg::BANK_TO_BANK_ACT_DELAY_CYC;
  localparam int ACT_COL = lps_pkg::ROW_TO_COL_DELAY_CYC;
  localparam int WR_PRE = lps_pkg::WRITE_RECOVERY_CYC;
  localparam int MRS_GAP = lps_pkg::MODE_LOAD_DELAY_CYC;
  // ----------------------------------------------------------------
  // command decode and age counters
  // ----------------------------------------------------------------
  logic [2:0] code;
  logic act, pre, col, wr, mrs, ref_c, dpd_entry;
  logic [7:0] since_act_reg [4];
  logic [7:0] since_any_reg, since_wr_reg, since_mrs_reg;
  logic dpd_reg;
  // guard after deep power down is far beyond any repetition count
  logic [15:0] wake_cnt_reg;
  assign code = {ras_n, cas_n, we_n};
  assign act = !cs_n && code == lps_pkg::LPS_ACT;
  assign pre = !cs_n && code == lps_pkg::LPS_PRE;
  assign wr = !cs_n && code == lps_pkg::LPS_WR;
  assign col = wr || (!cs_n && code == lps_pkg::LPS_RD);
  assign mrs = !cs_n && code == lps_pkg::LPS_MRS;
  assign ref_c = !cs_n && code == lps_pkg::LPS_REF;
  assign dpd_entry = !cs_n && code == lps_pkg::LPS_STOP && !cke;
  // saturate so an untouched bank never looks freshly opened
  function automatic logic [7:0] sat(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) since_act_reg[i] <= 8'hFF;
      since_any_reg <= 8'hFF;
      since_wr_reg <= 8'hFF;
      since_mrs_reg <= 8'hFF;
      dpd_reg <= 1'b0;
      wake_cnt_reg <= 16'hFFFF;
    end else begin
      for (int i = 0; i < 4; i++) begin
        since_act_reg[i] <= (act && ba == 2'(i)) ? 8'h01 : sat(since_act_reg[i]);
      end
      since_any_reg <= act ? 8'h01 : sat(since_any_reg);
      since_wr_reg <= wr ? 8'h01 : sat(since_wr_reg);
      since_mrs_reg <= mrs ? 8'h01 : sat(since_mrs_reg);
      dpd_reg <= dpd_entry ? 1'b1 : (cke ? 1'b0 : dpd_reg);
      if (dpd_reg && cke) wake_cnt_reg <= 16'h0001;
      else if (wake_cnt_reg != 16'hFFFF) wake_cnt_reg <= wake_cnt_reg + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_idle_cmd;
    cs_n || code == lps_pkg::LPS_NOP;
  endsequence
  sequence s_dpd_wake;
    dpd_reg && cke;
  endsequence
  chk_pre_after_act: assert property (pre |-> since_act_reg[ba] >= ACT_PRE)
    else $error("precharge too soon after activate");
  chk_row_cycle: assert property (act |-> since_act_reg[ba] >= ROW_CYC)
    else $error("same bank activate too soon");
  chk_bank_spacing: assert property (act |-> since_any_reg >= ACT_ACT)
    else $error("activates too close together");
  chk_row_to_col: assert property (col |-> since_act_reg[ba] >= ACT_COL)
    else $error("column command too soon after activate");
  chk_wdata_same_clk: assert property (wr |-> dq_ctl_oe && dq_mem_oe == 4'h0)
    else $error("write data not driven with write command");
  chk_write_recovery: assert property (pre |-> since_wr_reg >= WR_PRE)
    else $error("precharge inside write recovery");
  chk_read_mask_hiz: assert property (|dqm |-> ##2 (dq_mem_oe & $past(dqm, 2)) == 4'h0)
    else $error("masked byte still driven two clocks later");
  chk_mode_load_gap: assert property ((act || ref_c) |-> since_mrs_reg >= MRS_GAP)
    else $error("activate or refresh too soon after mode load");
  chk_dpd_exit_nop: assert property (s_dpd_wake |-> s_idle_cmd [*8])
    else $error("command issued right after deep power down exit");
  chk_dpd_exit_hold: assert property ((!cs_n && code != lps_pkg::LPS_NOP) |-> wake_cnt_reg >= DPD_NOP)
    else $error("command issued inside deep power down exit guard");
  cov_dpd_wake: cover property (s_dpd_wake);
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench: controller and sdram ends joined by the link
// assumes cas latency 3 from reset and a 16-word storage per device
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, req_valid, req_cke, req_ready, rd_valid, refresh_due;
  logic sr_tick, data_lost;
  logic [2:0] req_cmd, sr_region;
  logic [lps_pkg::BW-1:0] req_ba;
  logic [lps_pkg::AW-1:0] req_addr;
  logic [lps_pkg::DW-1:0] req_wdata, rd_data;
  logic [lps_pkg::MW-1:0] req_mask;
  logic [1:0] power_mode;
  logic [31:0] exp_w [4];
  logic [2:0] par_codes [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h2};
  int n_mismatch = 0;
  int n_tests = 0;
  int last_wait, n, t0;
  lps_if link ();
  lps_ctl lps_ctl_inst (.clock(clock), .arst_n(arst_n), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_mask(req_mask), .req_cke(req_cke), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .refresh_due(refresh_due), .bus(link));
  lps_mem lps_mem_inst (.clock(clock), .arst_n(arst_n), .bus(link),
    .power_mode(power_mode), .sr_region(sr_region), .sr_tick(sr_tick), .data_lost(data_lost));
  lps_chk lps_chk_inst (.clock(clock), .arst_n(arst_n), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .dqm(link.dqm), .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // called just after a rising edge; returns at the edge that takes it, valid still up
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [10:0] a,
      input logic [31:0] d, input logic [3:0] m, input logic k);
    req_cmd <= c;
    req_ba <= b;
    req_addr <= a;
    req_wdata <= d;
    req_mask <= m;
    req_cke <= k;
    req_valid <= 1'b1;
    last_wait = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && last_wait < 30000) begin
      @(negedge clock);
      last_wait++;
    end
    check(32'(last_wait < 30000), 32'h1, "request never taken");
    @(posedge clock);
  endtask
  task automatic idle(input int cyc);
    req_valid <= 1'b0;
    repeat (cyc) @(posedge clock);
  endtask
  task automatic wait_for(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    check(32'(n < lim), 32'h1, "wait ran out");
  endtask
  task automatic rd_burst(input logic [1:0] b, input logic [3:0] m);
    issue(lps_pkg::LPS_RD, b, 11'h000, 32'h0, m, 1'b1);
    idle(1);
    @(negedge clock);
    wait_for(rd_valid, 20);
    for (int k = 0; k < 4; k++) begin
      check(rd_data, exp_w[k] & ~{{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}}, "read word");
      @(negedge clock);
    end
    @(posedge clock);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = 3'h7;
    req_ba = 2'h0;
    req_addr = 11'h000;
    req_wdata = 32'h0;
    req_mask = 4'h0;
    req_cke = 1'b1;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    issue(lps_pkg::LPS_ACT, 2'h0, 11'h005, 32'h0, 4'h0, 1'b1);
    issue(lps_pkg::LPS_ACT, 2'h1, 11'h005, 32'h0, 4'h0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      exp_w[k] = 32'hA0B1C2D0 + 32'(k);
      issue(lps_pkg::LPS_WR, 2'h0, 11'(k), exp_w[k], 4'h0, 1'b1);
      if (k > 0) check(32'(last_wait), 32'h0, "column commands not back to back");
    end
    issue(lps_pkg::LPS_WR, 2'h0, 11'h002, 32'hFFFFFFFF, 4'h5, 1'b1);
    exp_w[2] = {8'hFF, exp_w[2][23:16], 8'hFF, exp_w[2][7:0]};
    idle(1);
    rd_burst(2'h0, 4'h0);
    $display("test write and mask done");
    issue(lps_pkg::LPS_PRE, 2'h0, 11'h000, 32'h0, 4'h0, 1'b1);
    issue(lps_pkg::LPS_ACT, 2'h0, 11'h009, 32'h0, 4'h0, 1'b1);
    idle(1);
    rd_burst(2'h0, 4'h0);
    rd_burst(2'h0, 4'h9);
    issue(lps_pkg::LPS_PRE, 2'h0, 11'h400, 32'h0, 4'h0, 1'b1);
    $display("test row cycle done");
    for (int i = 0; i < 5; i++) begin
      issue(lps_pkg::LPS_MRS, lps_pkg::EMR_BA, {6'h0, 2'h3, par_codes[i]}, 32'h0, 4'h0, 1'b1);
      idle(3);
      check(32'(sr_region), 32'(par_codes[i]), "partial array region");
    end
    $display("test extended mode done");
    issue(lps_pkg::LPS_REF, 2'h0, 11'h000, 32'h0, 4'h0, 1'b0);
    idle(3);
    check(32'(power_mode), 32'h2, "self refresh not entered");
    @(negedge clock);
    wait_for(sr_tick, 800);
    @(negedge clock);
    t0 = $time;
    wait_for(sr_tick, 800);
    n = ($time - t0) / 5 + 1;
    check(32'(n >= 383 && n <= 386), 32'h1, "self refresh tick rate");
    @(posedge clock);
    issue(lps_pkg::LPS_NOP, 2'h0, 11'h000, 32'h0, 4'h0, 1'b1);
    idle(3);
    check(32'(power_mode), 32'h0, "self refresh not left");
    issue(lps_pkg::LPS_ACT, 2'h0, 11'h009, 32'h0, 4'h0, 1'b1);
    idle(1);
    rd_burst(2'h0, 4'h0);
    issue(lps_pkg::LPS_PRE, 2'h0, 11'h400, 32'h0, 4'h0, 1'b1);
    idle(1);
    $display("test self refresh done");
    @(negedge clock);
    wait_for(refresh_due, 3300);
    @(posedge clock);
    issue(lps_pkg::LPS_REF, 2'h0, 11'h000, 32'h0, 4'h0, 1'b1);
    idle(2);
    @(negedge clock);
    check(32'(refresh_due), 32'h0, "refresh request not cleared");
    wait_for(refresh_due, 3300);
    check(32'(n >= 3000 && n + 4 <= 3125), 32'h1, "refresh interval");
    @(posedge clock);
    $display("test refresh interval done");
    issue(lps_pkg::LPS_STOP, 2'h0, 11'h000, 32'h0, 4'h0, 1'b0);
    idle(3);
    check({30'h0, power_mode}, 32'h3, "deep power down not entered");
    check(32'(data_lost), 32'h1, "array loss not flagged");
    issue(lps_pkg::LPS_NOP, 2'h0, 11'h000, 32'h0, 4'h0, 1'b1);
    idle(3);
    check(32'(power_mode), 32'h0, "deep power down not left");
    issue(lps_pkg::LPS_ACT, 2'h0, 11'h001, 32'h0, 4'h0, 1'b1);
    idle(3);
    check(32'(data_lost), 32'h0, "loss flag not cleared");
    $display("test deep power down done");
    report_and_stop();
  end
  initial begin
    #400us;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> inc/lps_if.sv
// command link between controller and low-power sdram
// assumes both ends share one clock; dq resolved here from the enables
`default_nettype none
interface lps_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [lps_pkg::BW-1:0] ba;
  logic [lps_pkg::AW-1:0] addr;
  logic [lps_pkg::MW-1:0] dqm;
  logic [lps_pkg::DW-1:0] dq_ctl_o;
  logic dq_ctl_oe;
  logic [lps_pkg::DW-1:0] dq_mem_o;
  logic [lps_pkg::MW-1:0] dq_mem_oe;
  logic [lps_pkg::DW-1:0] dq;
  always_comb begin
    for (int i = 0; i < lps_pkg::DW; i++) begin
      dq[i] = dq_mem_oe[i/8] ? dq_mem_o[i] : (dq_ctl_oe ? dq_ctl_o[i] : 1'b0);
    end
  end
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
    output dq_mem_o, dq_mem_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_o, dq_ctl_oe,
    input dq);
endinterface
`default_nettype wire

// >>> inc/lps_pkg.sv
// package for the low-power sdram timing link: timing constants, commands, modes
// assumes a single 200 MHz clock shared by both ends
`default_nettype none
package lps_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ACT_TO_PRE_MIN_PS = 42000;
  localparam int ACT_TO_PRE_MAX_PS = 100000000;
  localparam int ROW_CYCLE_TIME_PS = 60000;
  localparam int BANK_TO_BANK_ACT_DELAY_PS = 12000;
  localparam int ROW_TO_COL_DELAY_PS = 18000;
  localparam int WRITE_RECOVERY_PS = 12000;
  localparam int WRITE_AP_TO_ACT_PS = 30000;
  localparam int SELF_REFRESH_EXIT_DELAY_PS = 66000;
  localparam int DPD_EXIT_NOP_NS = 100000;
  localparam int REFRESH_WINDOW_MS = 64;
  localparam int REFRESH_ROWS = 4096;
  // least times round up, longest round down
  function automatic int cyc_up(input int ps);
    return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction
  localparam int ACT_TO_PRE_MIN_CYC = cyc_up(ACT_TO_PRE_MIN_PS);
  localparam int ACT_TO_PRE_MAX_CYC = ACT_TO_PRE_MAX_PS / CLK_PERIOD_PS;
  localparam int ROW_CYCLE_TIME_CYC = cyc_up(ROW_CYCLE_TIME_PS);
  localparam int BANK_TO_BANK_ACT_DELAY_CYC = cyc_up(BANK_TO_BANK_ACT_DELAY_PS);
  localparam int ROW_TO_COL_DELAY_CYC = cyc_up(ROW_TO_COL_DELAY_PS);
  localparam int WRITE_RECOVERY_CYC = cyc_up(WRITE_RECOVERY_PS);
  localparam int WRITE_AP_TO_ACT_CYC = cyc_up(WRITE_AP_TO_ACT_PS);
  localparam int SELF_REFRESH_EXIT_DELAY_CYC = cyc_up(SELF_REFRESH_EXIT_DELAY_PS);
  localparam int DPD_EXIT_NOP_CYC = DPD_EXIT_NOP_NS * 1000 / CLK_PERIOD_PS;
  localparam longint REFRESH_INTERVAL_CYC =
    longint'(REFRESH_WINDOW_MS) * 1000000000 / CLK_PERIOD_PS / REFRESH_ROWS;
  localparam int COL_CMD_SPACING_CYC = 1;
  localparam int WRITE_DATA_DELAY_CYC = 0;
  localparam int READ_MASK_HIZ_DELAY_CYC = 2;
  localparam int WRITE_MASK_DELAY_CYC = 0;
  localparam int MODE_LOAD_DELAY_CYC = 2;
  localparam int LAST_WDATA_TO_COL_CMD_CYC = 1;
  localparam int CLK_EN_ENTRY_DELAY_CYC = 1;
  localparam int CLK_EN_EXIT_DELAY_CYC = 1;
  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int DW = 32;
  localparam int MW = 4;
  localparam int AW = 11;
  localparam int BW = 2;
  localparam int MR_CL_LSB = 4;
  localparam int EMR_PAR_LSB = 0;
  localparam int EMR_TCR_LSB = 3;
  localparam logic [1:0] EMR_BA = 2'h2;
  localparam int AP_BIT = 10;
  localparam logic [2:0] CL_RESET = 3'h3;
  localparam logic [1:0] TCR_RESET = 2'h0;
  localparam logic [2:0] PAR_RESET = 3'h0;
  // command code {ras_n, cas_n, we_n} with cs_n low
  typedef enum logic [2:0] {
    LPS_MRS = 3'h0, LPS_REF = 3'h1, LPS_PRE = 3'h2, LPS_ACT = 3'h3,
    LPS_WR = 3'h4, LPS_RD = 3'h5, LPS_STOP = 3'h6, LPS_NOP = 3'h7
  } lps_cmd_t;
  // partial array region codes
  localparam logic [2:0] PAR_ALL = 3'h0;
  localparam logic [2:0] PAR_AB = 3'h1;
  localparam logic [2:0] PAR_A = 3'h2;
  localparam logic [2:0] PAR_HALF_A = 3'h5;
  localparam logic [2:0] PAR_QTR_A = 3'h6;
  // self refresh tick divisor per temperature setting (arbitrary scale)
  function automatic logic [11:0] tcr_div(input logic [1:0] t);
    case (t)
      2'h0: return 12'hC00;
      2'h1: return 12'h600;
      2'h2: return 12'h300;
      default: return 12'h180;
    endcase
  endfunction
  localparam int ROW_BITS = 11;
endpackage
`default_nettype wire

// >>> rtl/lps_ctl.sv
// controller end: issues one request at a time, gated by per-bank and shared minimum-spacing timers; a precharge of all banks checks only its own bank
// assumes the device honours its own latencies; cas latency fixed at reset value
`default_nettype none
module lps_ctl (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic [2:0] req_cmd,
  input wire logic [lps_pkg::BW-1:0] req_ba,
  input wire logic [lps_pkg::AW-1:0] req_addr,
  input wire logic [lps_pkg::DW-1:0] req_wdata,
  input wire logic [lps_pkg::MW-1:0] req_mask,
  input wire logic req_cke,
  output logic req_ready,
  output logic [lps_pkg::DW-1:0] rd_data,
  output logic rd_valid,
  output logic refresh_due,
  lps_if.ctl bus
);
  localparam int TW = 16;
  typedef struct packed {
    logic [3:0][7:0] act_t;
    logic [3:0][7:0] ras_t;
    logic [3:0][7:0] wr_t;
    logic [7:0] rrd_t;
    logic [7:0] mrd_t;
    logic [7:0] col_t;
    logic [TW-1:0] hold_t;
    logic [15:0] ref_t;
    logic ref_due;
    logic dpd;
    logic cke;
    lps_pkg::lps_cmd_t cmd;
    logic [lps_pkg::BW-1:0] ba;
    logic [lps_pkg::AW-1:0] addr;
    logic [lps_pkg::MW-1:0] dqm;
    logic [lps_pkg::DW-1:0] wd;
    logic oe;
    logic [6:0] rv;
    logic [lps_pkg::DW-1:0] rd;
    logic rd_v;
  } lps_ctl_st_t;
  lps_ctl_st_t st_reg;
  lps_ctl_st_t st_next;
  function automatic logic [7:0] dec(input logic [7:0] t);
    return (t == 8'h00) ? 8'h00 : t - 8'h01;
  endfunction
  lps_pkg::lps_cmd_t rc;
  logic ok;
  assign rc = lps_pkg::lps_cmd_t'(req_cmd);
  // ----------------------------------------------------------------
  // timing gate
  // ----------------------------------------------------------------
  always_comb begin
    ok = st_reg.hold_t == '0 && st_reg.mrd_t == 8'h00;
    case (rc)
      lps_pkg::LPS_ACT: ok = ok && st_reg.act_t[req_ba] == 8'h00
                          && st_reg.rrd_t == 8'h00;
      lps_pkg::LPS_RD, lps_pkg::LPS_WR, lps_pkg::LPS_STOP:
        ok = ok && st_reg.col_t == 8'h00;
      lps_pkg::LPS_PRE: ok = ok && st_reg.ras_t[req_ba] == 8'h00
                          && st_reg.wr_t[req_ba] == 8'h00;
      default: ;
    endcase
  end
  assign req_ready = ok;
  always_comb begin
    st_next = st_reg;
    for (int b = 0; b < 4; b++) begin
      st_next.act_t[b] = dec(st_reg.act_t[b]);
      st_next.ras_t[b] = dec(st_reg.ras_t[b]);
      st_next.wr_t[b] = dec(st_reg.wr_t[b]);
    end
    st_next.rrd_t = dec(st_reg.rrd_t);
    st_next.mrd_t = dec(st_reg.mrd_t);
    st_next.col_t = dec(st_reg.col_t);
    st_next.hold_t = (st_reg.hold_t == '0) ? '0 : st_reg.hold_t - 1'b1;
    // periodic refresh request so every row is visited per window
    if (st_reg.ref_t == 16'h0000) begin
      // reload cycle counts too, so the period stays within the interval
      st_next.ref_t = 16'(lps_pkg::REFRESH_INTERVAL_CYC - 1);
      st_next.ref_due = 1'b1;
    end else begin
      st_next.ref_t = st_reg.ref_t - 16'h0001;
    end
    st_next.cke = req_cke;
    st_next.cmd = lps_pkg::LPS_NOP;
    st_next.oe = 1'b0;
    st_next.dqm = req_mask;
    st_next.rv = {st_reg.rv[5:0], 1'b0};
    st_next.rd_v = 1'b0;
    // cke rising from low: nop guard, long one after deep power down
    if (req_cke && !st_reg.cke) begin
      st_next.dpd = 1'b0;
      st_next.hold_t = st_reg.dpd
                       ? TW'(lps_pkg::DPD_EXIT_NOP_CYC)
                       : TW'(lps_pkg::SELF_REFRESH_EXIT_DELAY_CYC);
    end
    if (req_valid && ok) begin
      st_next.cmd = rc;
      st_next.ba = req_ba;
      st_next.addr = req_addr;
      case (rc)
        lps_pkg::LPS_ACT: begin
          st_next.act_t[req_ba] = 8'(lps_pkg::ROW_CYCLE_TIME_CYC);
          st_next.ras_t[req_ba] = 8'(lps_pkg::ACT_TO_PRE_MIN_CYC);
          st_next.rrd_t = 8'(lps_pkg::BANK_TO_BANK_ACT_DELAY_CYC);
          st_next.col_t = 8'(lps_pkg::ROW_TO_COL_DELAY_CYC);
        end
        lps_pkg::LPS_WR: begin
          st_next.oe = 1'b1;
          st_next.wd = req_wdata;
          st_next.wr_t[req_ba] = 8'(lps_pkg::WRITE_RECOVERY_CYC);
          // gate adds one cycle of its own, back-to-back must stay legal
          st_next.col_t = 8'(lps_pkg::LAST_WDATA_TO_COL_CMD_CYC - 1);
          if (req_addr[lps_pkg::AP_BIT])
            st_next.act_t[req_ba] = 8'(lps_pkg::WRITE_AP_TO_ACT_CYC);
        end
        lps_pkg::LPS_RD: st_next.rv[0] = 1'b1;
        lps_pkg::LPS_MRS: st_next.mrd_t = 8'(lps_pkg::MODE_LOAD_DELAY_CYC);
        lps_pkg::LPS_REF: st_next.ref_due = 1'b0;
        lps_pkg::LPS_STOP: st_next.dpd = !req_cke;
        default: ;
      endcase
    end
    // capture the four burst words, the first at cas latency 3
    if (|st_reg.rv[6:3]) begin
      st_next.rd = bus.dq;
      st_next.rd_v = 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.cmd <= lps_pkg::LPS_NOP;
      st_reg.cke <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign bus.cke = st_reg.cke;
  assign bus.cs_n = 1'b0;
  assign {bus.ras_n, bus.cas_n, bus.we_n} = st_reg.cmd;
  assign bus.ba = st_reg.ba;
  assign bus.addr = st_reg.addr;
  assign bus.dqm = st_reg.dqm;
  assign bus.dq_ctl_o = st_reg.wd;
  assign bus.dq_ctl_oe = st_reg.oe;
  assign rd_data = st_reg.rd;
  assign rd_valid = st_reg.rd_v;
  assign refresh_due = st_reg.ref_due;
endmodule
`default_nettype wire

// >>> rtl/lps_mem.sv
// device end: command decode, masks, output timing, low-power modes
// assumes the controller keeps its own timing; storage is small flip-flop array
`default_nettype none
module lps_mem (
  input wire logic clock,
  input wire logic arst_n,
  lps_if.mem bus,
  output logic [1:0] power_mode,
  output logic [2:0] sr_region,
  output logic sr_tick,
  output logic data_lost
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LPS_ST_RUN = 4'h1, LPS_ST_PD = 4'h2, LPS_ST_SR = 4'h4, LPS_ST_DPD = 4'h8
  } lps_mode_t;
  localparam int DEPTH = 16;
  typedef struct packed {
    lps_mode_t mode;
    logic cke_d;
    logic [3:0] open_bank;
    logic [2:0] cl;
    logic [1:0] tcr;
    logic [2:0] par;
    logic [3:0] rd_left;
    logic [1:0] bank;
    logic [7:0] col;
    logic [3:0][lps_pkg::DW-1:0] pipe;
    logic [3:0] pipe_v;
    logic [1:0][lps_pkg::MW-1:0] mask_d;
    logic [lps_pkg::DW-1:0] dout;
    logic [lps_pkg::MW-1:0] oe;
    logic [11:0] tick_cnt;
    logic tick;
    logic lost;
    logic [DEPTH-1:0][lps_pkg::DW-1:0] mem;
  } lps_mem_st_t;
  lps_mem_st_t st_reg;
  lps_mem_st_t st_next;
  function automatic logic [3:0] idx(input logic [1:0] b, input logic [7:0] c);
    return {b, c[1:0]};
  endfunction
  lps_pkg::lps_cmd_t cmd;
  logic sel;
  logic [lps_pkg::DW-1:0] wmerged;
  assign cmd = lps_pkg::lps_cmd_t'({bus.ras_n, bus.cas_n, bus.we_n});
  // command is only seen while clock enable was high the cycle before
  assign sel = !bus.cs_n && st_reg.cke_d;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    wmerged = '0;
    st_next.cke_d = bus.cke;
    st_next.tick = 1'b0;
    // mask pipeline for the read mask delay
    st_next.mask_d = {st_reg.mask_d[0], bus.dqm};
    // low-power entry and exit, one clock after cke moves
    case (st_reg.mode)
      LPS_ST_RUN: begin
        if (st_reg.cke_d && !bus.cke && st_reg.open_bank == 4'h0) begin
          if (sel && cmd == lps_pkg::LPS_STOP) begin
            st_next.mode = LPS_ST_DPD;
            st_next.lost = 1'b1;
          end else if (sel && cmd == lps_pkg::LPS_REF) begin
            st_next.mode = LPS_ST_SR;
          end else begin
            st_next.mode = LPS_ST_PD;
          end
        end
      end
      LPS_ST_PD: if (bus.cke) st_next.mode = LPS_ST_RUN;
      LPS_ST_SR: begin
        if (bus.cke) st_next.mode = LPS_ST_RUN;
        // internal refresh pace follows the temperature setting
        if (st_reg.tick_cnt == 12'h000) begin
          st_next.tick_cnt = lps_pkg::tcr_div(st_reg.tcr);
          st_next.tick = 1'b1;
        end else begin
          st_next.tick_cnt = st_reg.tick_cnt - 12'h001;
        end
      end
      LPS_ST_DPD: if (bus.cke) st_next.mode = LPS_ST_RUN;
      default: st_next.mode = LPS_ST_RUN;
    endcase
    // entering self refresh drops data outside the chosen region
    if (st_reg.mode == LPS_ST_RUN && st_next.mode == LPS_ST_SR) begin
      for (int i = 0; i < DEPTH; i++) begin
        case (st_reg.par)
          lps_pkg::PAR_ALL: ;
          lps_pkg::PAR_AB: if (i[3:2] > 2'h1) st_next.mem[i] = '0;
          lps_pkg::PAR_A: if (i[3:2] != 2'h0) st_next.mem[i] = '0;
          lps_pkg::PAR_HALF_A: if (i[3:1] != 3'h0) st_next.mem[i] = '0;
          lps_pkg::PAR_QTR_A: if (i != 0) st_next.mem[i] = '0;
          default: ;
        endcase
      end
      st_next.tick_cnt = lps_pkg::tcr_div(st_reg.tcr);
    end
    if (st_next.mode == LPS_ST_DPD) st_next.mem = '0;
    if (st_reg.mode == LPS_ST_RUN && sel && bus.cke) st_next.lost = 1'b0;
    // read burst pipeline: cas latency stages
    st_next.pipe = {st_reg.pipe[2:0], st_reg.mem[idx(st_reg.bank, st_reg.col)]};
    st_next.pipe_v = {st_reg.pipe_v[2:0], st_reg.rd_left != 4'h0};
    if (st_reg.rd_left != 4'h0) begin
      st_next.rd_left = st_reg.rd_left - 4'h1;
      st_next.col = st_reg.col + 8'h01;
    end
    if (st_reg.mode == LPS_ST_RUN && sel) begin
      case (cmd)
        lps_pkg::LPS_MRS: begin
          if (bus.ba == lps_pkg::EMR_BA) begin
            st_next.par = bus.addr[lps_pkg::EMR_PAR_LSB +: 3];
            st_next.tcr = bus.addr[lps_pkg::EMR_TCR_LSB +: 2];
          end else begin
            st_next.cl = bus.addr[lps_pkg::MR_CL_LSB +: 3];
          end
        end
        lps_pkg::LPS_ACT: st_next.open_bank[bus.ba] = 1'b1;
        lps_pkg::LPS_PRE: begin
          if (bus.addr[lps_pkg::AP_BIT]) st_next.open_bank = 4'h0;
          else st_next.open_bank[bus.ba] = 1'b0;
          // ends the burst; queued words still leave per latency
          st_next.rd_left = 4'h0;
        end
        lps_pkg::LPS_RD: begin
          st_next.bank = bus.ba;
          st_next.col = bus.addr[7:0];
          st_next.rd_left = 4'h4;
        end
        lps_pkg::LPS_WR: begin
          st_next.rd_left = 4'h0;
          // data taken on the command edge, masked lanes kept
          for (int b = 0; b < lps_pkg::MW; b++) begin
            wmerged[b*8 +: 8] = bus.dqm[b] ? st_reg.mem[idx(bus.ba, bus.addr[7:0])][b*8 +: 8]
                                           : bus.dq[b*8 +: 8];
          end
          st_next.mem[idx(bus.ba, bus.addr[7:0])] = wmerged;
        end
        lps_pkg::LPS_STOP: st_next.rd_left = 4'h0;
        default: ;
      endcase
    end
    // output stage is itself a register, so latency 2 reads the array directly
    st_next.dout = (st_reg.cl == 3'h2) ? st_reg.mem[idx(st_reg.bank, st_reg.col)]
                                       : st_reg.pipe[0];
    for (int b = 0; b < lps_pkg::MW; b++) begin
      st_next.oe[b] = ((st_reg.cl == 3'h2) ? (st_reg.rd_left != 4'h0) : st_reg.pipe_v[0])
                      && !st_reg.mask_d[0][b];
    end
    // clock suspend freezes the data path
    if (!st_reg.cke_d && st_reg.mode == LPS_ST_RUN) begin
      st_next.pipe = st_reg.pipe;
      st_next.pipe_v = st_reg.pipe_v;
      st_next.rd_left = st_reg.rd_left;
      st_next.col = st_reg.col;
      st_next.dout = st_reg.dout;
      st_next.oe = st_reg.oe;
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.mode <= LPS_ST_RUN;
      st_reg.cl <= lps_pkg::CL_RESET;
      st_reg.tcr <= lps_pkg::TCR_RESET;
      st_reg.par <= lps_pkg::PAR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
  assign bus.dq_mem_o = st_reg.dout;
  assign bus.dq_mem_oe = st_reg.oe;
  assign power_mode = st_reg.mode == LPS_ST_PD ? 2'h1 : st_reg.mode == LPS_ST_SR ? 2'h2 :
                      st_reg.mode == LPS_ST_DPD ? 2'h3 : 2'h0;
  assign sr_region = st_reg.par;
  assign sr_tick = st_reg.tick;
  assign data_lost = st_reg.lost;
endmodule
`default_nettype wire
